// file: src/vid_port_pkg.sv
package vid_port_pkg;
   localparam logic [6:0] ADDR_UPPER = 7'h60;
   localparam logic [7:0] OFF_VSEL1 = 8'h00;
   localparam logic [7:0] OFF_VSEL2 = 8'h01;
   localparam logic [7:0] OFF_CMD1 = 8'h02;
   localparam logic [7:0] OFF_CMD2 = 8'h03;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] RST_VSEL = 8'h00;
   localparam logic [7:0] RST_CMD = 8'h00;
   localparam logic [7:0] CMD_WMASK = 8'h77;
   localparam int GO_BIT = 7;
   localparam int TEMP_BIT = 2;
   localparam int PG2_BIT = 1;
   localparam int PG1_BIT = 0;
   typedef enum logic [1:0] {STRAP_GND, STRAP_HIGH, STRAP_OPEN} strap_t;
   typedef struct packed {
      logic active;
      logic [6:0] code;
   } vid_t;
   typedef struct packed {
      logic overTemp;
      logic output2_in_regulation_flag;
      logic output1_in_regulation_flag;
   } status_t;
endpackage : vid_port_pkg

// file: src/dual_vid_i2c_register_port.sv
`timescale 1ns/100ps
module dual_vid_i2c_register_port (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire vid_port_pkg::strap_t addrStrap,
   input wire logic converter_one_enable_pin,
   input wire logic converter_two_enable_pin,
   input wire vid_port_pkg::status_t health,
   output vid_port_pkg::vid_t output1_voltage_code,
   output vid_port_pkg::vid_t output2_voltage_code,
   output logic [7:0] output1_command,
   output logic [7:0] output2_command,
   output logic output1_activation_flag,
   output logic output2_activation_flag
);
   typedef enum {IDLE, ADDR, ADDR_ACK, REG, REG_ACK, WDATA, WDATA_ACK, RDATA, RDATA_ACK,
      IGNORE} state_t;
   state_t state;
   logic [1:0] sclSync, sdaSync, enSync1, enSync2;
   logic sclPrev, sdaPrev;
   logic [7:0] shift, regPtr, txByte;
   logic [3:0] bitCnt;
   logic readMode;
   logic [2:0] healthMeta, healthSync;
   vid_port_pkg::strap_t strapMeta, strapSync;
   always_ff @(posedge clk) begin
      if (rst) begin
         sclSync <= 2'h3; // idle high, so no false edge right after reset
         sdaSync <= 2'h3;
         enSync1 <= 2'h0;
         enSync2 <= 2'h0;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
         healthMeta <= 3'h0;
         healthSync <= 3'h0;
         strapMeta <= vid_port_pkg::STRAP_GND;
         strapSync <= vid_port_pkg::STRAP_GND;
      end else begin
         sclSync <= {sclSync[0], sclIn};
         sdaSync <= {sdaSync[0], sdaIn};
         enSync1 <= {enSync1[0], converter_one_enable_pin};
         enSync2 <= {enSync2[0], converter_two_enable_pin};
         sclPrev <= sclSync[1];
         sdaPrev <= sdaSync[1];
         healthMeta <= health;
         healthSync <= healthMeta;
         strapMeta <= addrStrap;
         strapSync <= strapMeta;
      end
   end
   wire scl = sclSync[1];
   wire sda = sdaSync[1];
   wire sclRise = scl && !sclPrev;
   wire sclFall = !scl && sclPrev;
   wire startCond = scl && sclPrev && sdaPrev && !sda;
   wire stopCond = scl && sclPrev && !sdaPrev && sda;
   wire [1:0] strapBits = (strapSync == vid_port_pkg::STRAP_HIGH) ? 2'h1 :
      (strapSync == vid_port_pkg::STRAP_OPEN) ? 2'h2 : 2'h0;
   wire [6:0] myAddr = vid_port_pkg::ADDR_UPPER | {5'h00, strapBits};
   wire [7:0] rxByte = {shift[6:0], sda};
   wire [7:0] rxByteHold = shift;
   wire byteDone = sclFall && bitCnt == 4'h8;
   // ack clocks are not data bits and must not advance the bit counter
   wire dataPhase = state == ADDR || state == REG || state == WDATA || state == RDATA;
   wire hwShutdown = !enSync1[1] && !enSync2[1];
   wire addrHit = shift[7:1] == myAddr;
   wire writeEn = state == WDATA && byteDone && !hwShutdown;
   wire [7:0] statusByte = {5'h00, healthSync};
   wire [7:0] readMux = (regPtr == vid_port_pkg::OFF_VSEL1) ? output1_voltage_code :
      (regPtr == vid_port_pkg::OFF_VSEL2) ? output2_voltage_code :
      (regPtr == vid_port_pkg::OFF_CMD1) ? output1_command :
      (regPtr == vid_port_pkg::OFF_CMD2) ? output2_command :
      (regPtr == vid_port_pkg::OFF_STATUS) ? statusByte : 8'h00;
   // bit counter counts sampled bits; 8 means byte complete at next fall
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= IDLE;
         shift <= 8'h00;
         bitCnt <= 4'h0;
         regPtr <= 8'h00;
         readMode <= 1'b0;
         txByte <= 8'h00;
      end else if (startCond) begin
         state <= ADDR;
         bitCnt <= 4'h0;
      end else if (stopCond) begin
         state <= IDLE;
      end else begin
         if (sclRise && dataPhase && bitCnt != 4'h8) begin
            shift <= rxByte;
            bitCnt <= bitCnt + 4'h1;
         end
         if (sclRise && state == RDATA_ACK && sda) begin
            state <= IGNORE; // master nack ends the read
         end
         if (sclFall) begin
            case (state)
               ADDR: if (bitCnt == 4'h8) begin
                  bitCnt <= 4'h0;
                  state <= addrHit ? ADDR_ACK : IGNORE;
                  readMode <= shift[0];
                  txByte <= readMux;
               end
               ADDR_ACK: state <= readMode ? RDATA : REG;
               REG: if (bitCnt == 4'h8) begin
                  bitCnt <= 4'h0;
                  regPtr <= shift;
                  state <= REG_ACK;
               end
               REG_ACK: state <= WDATA;
               WDATA: if (bitCnt == 4'h8) begin
                  bitCnt <= 4'h0;
                  state <= WDATA_ACK;
               end
               WDATA_ACK: begin
                  state <= WDATA;
                  regPtr <= regPtr + 8'h01;
               end
               RDATA: if (bitCnt == 4'h8) begin
                  bitCnt <= 4'h0;
                  state <= RDATA_ACK;
                  regPtr <= regPtr + 8'h01; // advance now so the reload below sees it
               end else begin
                  txByte <= {txByte[6:0], 1'b0};
               end
               RDATA_ACK: begin
                  state <= RDATA;
                  txByte <= readMux;
               end
               default: state <= state;
            endcase
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         output1_voltage_code <= vid_port_pkg::RST_VSEL;
         output2_voltage_code <= vid_port_pkg::RST_VSEL;
         output1_command <= vid_port_pkg::RST_CMD;
         output2_command <= vid_port_pkg::RST_CMD;
      end else if (writeEn) begin
         if (regPtr == vid_port_pkg::OFF_VSEL1) begin
            output1_voltage_code <= rxByteHold;
         end else if (regPtr == vid_port_pkg::OFF_VSEL2) begin
            output2_voltage_code <= rxByteHold;
         end else if (regPtr == vid_port_pkg::OFF_CMD1) begin
            output1_command <= rxByteHold & vid_port_pkg::CMD_WMASK;
         end else if (regPtr == vid_port_pkg::OFF_CMD2) begin
            output2_command <= rxByteHold & vid_port_pkg::CMD_WMASK;
         end
      end
   end
   assign output1_activation_flag = output1_voltage_code.active;
   assign output2_activation_flag = output2_voltage_code.active;
   // ack states drive low for the whole high phase; read data only while reading
   wire ackDrive = state == ADDR_ACK || state == REG_ACK || state == WDATA_ACK;
   wire readDrive = state == RDATA && !txByte[7];
   always_ff @(posedge clk) begin
      if (rst) begin
         sdaOe <= 1'b0;
      end else begin
         sdaOe <= ackDrive || readDrive;
      end
   end
   assign sdaOut = 1'b0;

   property p_nack_foreign;
      @(posedge clk) disable iff (rst) state == IGNORE |-> !sdaOe;
   endproperty
   a_nack_foreign: assert property (p_nack_foreign) else $error("drove sda while ignoring");
   property p_shutdown_blocks;
      @(posedge clk) disable iff (rst) hwShutdown |=> $stable(output1_voltage_code);
   endproperty
   a_shutdown_blocks: assert property (p_shutdown_blocks) else $error("write in shutdown");
   property p_commit_on_fall;
      @(posedge clk) disable iff (rst) $changed(output2_voltage_code) |-> $past(writeEn);
   endproperty
   a_commit_on_fall: assert property (p_commit_on_fall) else $error("update off the edge");
   property p_ack_held;
      @(posedge clk) disable iff (rst) (ackDrive && scl) |-> sdaOe;
   endproperty
   a_ack_held: assert property (p_ack_held) else $error("ack not driven");
   property p_cmd_reserved;
      @(posedge clk) disable iff (rst) output1_command[7] == 1'b0 && output1_command[3] == 1'b0;
   endproperty
   a_cmd_reserved: assert property (p_cmd_reserved) else $error("reserved bit set");
   property p_idle_released;
      @(posedge clk) disable iff (rst) state == IDLE |=> !sdaOe;
   endproperty
   a_idle_released: assert property (p_idle_released) else $error("sda driven idle");
   property p_flag_follow;
      @(posedge clk) disable iff (rst)
         (writeEn && regPtr == vid_port_pkg::OFF_VSEL1) |=>
         output1_activation_flag == $past(shift[7]);
   endproperty
   a_flag_follow: assert property (p_flag_follow) else $error("flag mismatch");
   property p_hit_ack;
      @(posedge clk) disable iff (rst)
         (state == ADDR && byteDone && addrHit && !startCond && !stopCond) |=> state == ADDR_ACK;
   endproperty
   a_hit_ack: assert property (p_hit_ack) else $error("own address not acked");
   c_write: cover property (@(posedge clk) writeEn);
   c_read: cover property (@(posedge clk) state == RDATA);
   c_foreign: cover property (@(posedge clk) state == IGNORE);
   c_shutdown: cover property (@(posedge clk) state == WDATA && byteDone && hwShutdown);
endmodule : dual_vid_i2c_register_port

// file: testbench/i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sdaLow
);
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // quarter of the 160 ns serial clock period
   task automatic q();
      repeat (2) @(posedge clk);
      #1;
   endtask : q
   task automatic bitx(input logic b, output logic r);
      sdaLow = ~b;
      q();
      scl = 1'b1;
      q();
      q();
      r = sda;
      scl = 1'b0;
      q();
   endtask : bitx
   // also serves as repeated start, entered with the clock low
   task automatic start();
      sdaLow = 1'b0;
      q();
      scl = 1'b1;
      q();
      sdaLow = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask : start
   task automatic stop();
      sdaLow = 1'b1;
      q();
      scl = 1'b1;
      q();
      sdaLow = 1'b0;
      q();
   endtask : stop
   // ninth bit released: nack after the final read byte
   task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ackd);
      logic b;
      for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
      bitx(1'b1, b);
      ackd = ~b;
   endtask : xfer
endmodule : i2c_master_model

// file: testbench/tb_dual_vid_i2c_register_port.sv
`timescale 1ns/100ps
module tb_dual_vid_i2c_register_port;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic scl, sdaLow, sdaOut, sdaOe, k, ak, f1, f2;
   logic en1 = 1'b1;
   logic en2 = 1'b1;
   logic [6:0] adr;
   logic [7:0] c1, c2, rd;
   vid_port_pkg::strap_t strap = vid_port_pkg::STRAP_GND;
   vid_port_pkg::status_t health = 3'b000;
   vid_port_pkg::vid_t v1, v2;
   int errors = 0;
   int total_checks = 0;
   // pull-up: released line reads high
   wire logic sda = ~(sdaLow | (sdaOe & ~sdaOut));
   always #10 clk = ~clk;
   i2c_master_model i2c_master_model_i (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
   dual_vid_i2c_register_port dual_vid_i2c_register_port_i (.clk(clk), .rst(rst),
      .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(strap),
      .converter_one_enable_pin(en1), .converter_two_enable_pin(en2), .health(health),
      .output1_voltage_code(v1), .output2_voltage_code(v2), .output1_command(c1),
      .output2_command(c2), .output1_activation_flag(f1), .output2_activation_flag(f2));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
      i2c_master_model_i.start();
      i2c_master_model_i.xfer({a, 1'b0}, rd, ak);
      if (ak) begin
         i2c_master_model_i.xfer(r, rd, k);
         i2c_master_model_i.xfer(d, rd, k);
      end
      i2c_master_model_i.stop();
   endtask : wr
   task automatic rdreg(input logic [7:0] r);
      i2c_master_model_i.start();
      i2c_master_model_i.xfer({adr, 1'b0}, rd, k);
      i2c_master_model_i.xfer(r, rd, k);
      i2c_master_model_i.start();
      i2c_master_model_i.xfer({adr, 1'b1}, rd, k);
      i2c_master_model_i.xfer(8'hFF, rd, k);
      i2c_master_model_i.stop();
   endtask : rdreg
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(v1, vid_port_pkg::RST_VSEL);
      for (int s = 0; s < 3; s++) begin
         strap = vid_port_pkg::strap_t'(s);
         adr = vid_port_pkg::ADDR_UPPER | 7'(s);
         wr(adr, vid_port_pkg::OFF_VSEL1, 8'(s + 8'h80));
         chk({7'h00, ak}, 8'h01);
         chk(v1, 8'(s + 8'h80));
         wr(adr ^ 7'h04, vid_port_pkg::OFF_VSEL1, 8'h11);
         chk({7'h00, ak}, 8'h00);
         chk(v1, 8'(s + 8'h80));
      end
      wr(7'h00, vid_port_pkg::OFF_VSEL1, 8'h22);
      chk({7'h00, ak}, 8'h00);
      chk({7'h00, f1}, 8'h01);
      $display("address test done");
      wr(adr, vid_port_pkg::OFF_VSEL2, 8'h7F);
      chk({f2, v2.code}, 8'h7F);
      wr(adr, vid_port_pkg::OFF_VSEL2, 8'hA5);
      chk({7'h00, f2}, 8'h01);
      rdreg(vid_port_pkg::OFF_VSEL2);
      chk(rd, 8'hA5);
      wr(adr, vid_port_pkg::OFF_CMD1, 8'hFF);
      rdreg(vid_port_pkg::OFF_CMD1);
      chk(rd, vid_port_pkg::CMD_WMASK);
      health = 3'b101;
      wr(adr, vid_port_pkg::OFF_STATUS, 8'h00);
      rdreg(vid_port_pkg::OFF_STATUS);
      chk(rd, 8'h05);
      $display("register test done");
      en1 = 1'b0;
      en2 = 1'b0;
      wr(adr, vid_port_pkg::OFF_VSEL1, 8'h3C);
      chk(v1, 8'h82);
      en1 = 1'b1;
      en2 = 1'b1;
      wr(adr, vid_port_pkg::OFF_CMD1, 8'h01);
      chk(c1, 8'h01);
      wr(adr, vid_port_pkg::OFF_CMD2, 8'h01);
      chk(c2, 8'h01);
      wr(adr, vid_port_pkg::OFF_VSEL1, 8'h3C);
      chk(v1, 8'h3C);
      chk({7'h00, f1}, 8'h00);
      $display("shutdown test done");
      end_sim();
   end
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      end_sim();
   end
endmodule : tb_dual_vid_i2c_register_port
